// ===== rtl/hssq_sequencer.sv
module hssq_sequencer #(
	parameter int CYC_PER_MS_P = hssq_pkg::CYC_PER_MS,
	parameter int INIT_MS = hssq_pkg::HUBINIT_MS,
	parameter int CFG_MS = hssq_pkg::HUBCONFIG_MS,
	parameter int DET_MS = hssq_pkg::CHGDET_MS,
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys, // 40 MHz system clock
	input wire logic rst_b, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic hubRstPin_b, // Reset pin, low selects standby
	input wire logic bypassPin_b, // Bypass pin, low selects bypass
	input wire logic refClkPin, // Reference clock pin, sampled
	input wire logic pllLockPin, // PLL lock indication
	input wire logic dfltChgDetPin, // Built-in default for detection enable
	input wire logic dfltCfgHoldPin, // Built-in default for configuration hold
	input wire logic chgResultPin, // Charger found by detector
	output logic upstreamDplus, // D+ pull-up enable
	output logic eventOut, // Event pin output value
	output logic eventOe_b, // Event pin enable, low drives
	output logic ringOscEn, // Ring oscillator clocks early detection
	output logic chgDetRun, // Detector sequence running
	output hssq_pkg::hssq_stage_t stage // Current hub stage
);
	import hssq_pkg::*;

	if (CYC_PER_MS_P <= CONNECT_CYC || CYC_PER_MS_P > 65535) begin : g_chk_tick
		$error("CYC_PER_MS_P out of range");
	end
	if (INIT_MS < 1 || CFG_MS < 1 || DET_MS < 1 || CFG_MS > 1023 || DET_MS > 1023
		|| INIT_MS > 1023) begin : g_chk_ms
		$error("Stage times must be 1 to 1023 ms");
	end
	if (ADDR_W < 8) begin : g_chk_addr
		$error("ADDR_W too small");
	end

	localparam logic [15:0] TICK_LAST = 16'(CYC_PER_MS_P - 1);
	localparam logic [15:0] CONN_LAST = 16'(CONNECT_CYC - 1);
	localparam logic [9:0] INIT_LIM = 10'(INIT_MS);
	localparam logic [9:0] CFG_LIM = 10'(CFG_MS);
	localparam logic [9:0] DET_LIM = 10'(DET_MS);
	localparam logic [4:0] REF_WIN = 5'(REF_WIN_CYC);

	// Two-flop synchronisers for every pin
	logic [6:0] pinS1_r;
	logic [6:0] pinS2_r;
	wire logic [6:0] pinRaw = {chgResultPin, dfltCfgHoldPin, dfltChgDetPin,
		pllLockPin, refClkPin, bypassPin_b, hubRstPin_b};
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pinS1_r <= 7'h00;
			pinS2_r <= 7'h00;
		end
		else
		begin
			pinS1_r <= pinRaw;
			pinS2_r <= pinS1_r;
		end
	end
	wire logic hubMode = pinS2_r[0] && pinS2_r[1];
	wire logic refSync = pinS2_r[2];
	wire logic pllSync = pinS2_r[3];
	wire logic dfltChgDet = pinS2_r[4];
	wire logic dfltCfgHold = pinS2_r[5];
	wire logic chgResult = pinS2_r[6];

	// Refclk activity: an edge seen within a short window counts as toggling
	logic refS3_r;
	logic [4:0] refIdle_r;
	logic refActive_r;
	wire logic refEdge = refSync ^ refS3_r;
	wire logic [4:0] refIdle_nxt = refEdge ? 5'h00 :
		(refIdle_r == REF_WIN) ? refIdle_r : refIdle_r + 5'h01;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			refS3_r <= 1'b0;
			refIdle_r <= REF_WIN;
			refActive_r <= 1'b0;
		end
		else
		begin
			refS3_r <= refSync;
			refIdle_r <= refIdle_nxt;
			refActive_r <= refIdle_nxt != REF_WIN;
		end
	end

	// Stage register and millisecond timing
	hssq_stage_t stage_r;
	hssq_stage_t stage_nxt;
	logic [15:0] msCnt_r;
	logic [9:0] stgMs_r;
	logic cfgHold_r;
	logic heldSeen_r;
	logic chgDetEn_r;
	logic connWait_r;
	logic hsPulse_r;
	logic earlyRun_r;
	logic earlyDone_r;
	logic earlyRes_r;

	wire logic stageChange = stage_nxt != stage_r;
	wire logic msTick = msCnt_r == TICK_LAST;
	wire logic [9:0] stgLim = (stage_r == STG_INIT) ? INIT_LIM :
		(stage_r == STG_CONFIG) ? CFG_LIM : DET_LIM;
	wire logic limitHit = stgMs_r == stgLim;
	wire logic refReady = refActive_r && pllSync;

	always_comb
	begin
		stage_nxt = stage_r;
		case (stage_r)
			STG_OFF: stage_nxt = STG_INIT;
			STG_INIT: if (limitHit) stage_nxt = refReady ? STG_CONFIG : STG_WAITREF;
			STG_WAITREF: if (refReady) stage_nxt = STG_CONFIG;
			// Timeout counts from stage entry, so detection starts init plus config after entry
			STG_CONFIG: if (!cfgHold_r && (heldSeen_r || limitHit)) stage_nxt = STG_CHGDET;
			STG_CHGDET: if (!chgDetEn_r || limitHit) stage_nxt = STG_CONNECT;
			STG_CONNECT: if (!connWait_r || hsPulse_r) stage_nxt = STG_ATTACH;
			STG_ATTACH: if (msCnt_r == CONN_LAST) stage_nxt = STG_COMM;
			STG_COMM: stage_nxt = STG_COMM;
			default: stage_nxt = STG_OFF;
		endcase
		if (!hubMode)
			stage_nxt = STG_OFF;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage_r <= STG_OFF;
			msCnt_r <= 16'h0000;
			stgMs_r <= 10'h000;
		end
		else
		begin
			stage_r <= stage_nxt;
			msCnt_r <= (stageChange || msTick) ? 16'h0000 : msCnt_r + 16'h0001;
			stgMs_r <= stageChange ? 10'h000 : (msTick ? stgMs_r + 10'h001 : stgMs_r);
		end
	end
	assign stage = stage_r;

	// Early detection in wait-refclk, clocked by the ring oscillator
	wire logic earlyStart = stageChange && stage_nxt == STG_WAITREF && !refActive_r
		&& chgDetEn_r;
	wire logic earlyAbort = earlyRun_r && pllSync;
	wire logic earlyFinish = earlyRun_r && !pllSync && stgMs_r == DET_LIM;
	wire logic earlyRun_nxt = earlyStart || (earlyRun_r && !earlyAbort && !earlyFinish
		&& stage_nxt == STG_WAITREF);

	// APB slave: one wait state, answer registered
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	wire logic apbAcc = psel && penable && !pready_r;
	wire logic busOpen = stage_r == STG_CONFIG || stage_r == STG_CHGDET
		|| stage_r == STG_CONNECT || stage_r == STG_ATTACH;
	wire logic [7:0] addrLow = paddr[7:0];
	wire logic addrHigh = (ADDR_W > 8) ? (paddr >> 8) != '0 : 1'b0;
	wire logic selGate = !addrHigh && addrLow == ADDR_STAGE_GATE;
	wire logic selCfg = !addrHigh && addrLow == ADDR_PORTABLE_CFG;
	wire logic selStat = !addrHigh && addrLow == ADDR_STATUS;
	wire logic mapped = selGate || selCfg || selStat;
	// Write lands on the edge where the master sees pready; refused accesses never reach here
	wire logic wrDo = psel && penable && pready_r && pwrite && !pslverr_r;
	wire logic wrGate = wrDo && selGate;
	wire logic wrCfg = wrDo && selCfg;
	wire logic wrStat = wrDo && selStat;
	wire logic [31:0] rdGate = {30'h0, 1'b0, cfgHold_r};
	wire logic [31:0] rdCfg = {30'h0, connWait_r, chgDetEn_r};
	wire logic [31:0] rdStat = {22'h0, earlyRes_r, earlyDone_r, 1'b0, earlyRun_r,
		pllSync, refActive_r, 1'b0, 3'(stage_r)};
	wire logic [31:0] rdMux = selGate ? rdGate : selCfg ? rdCfg : selStat ? rdStat : 32'h0;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= apbAcc;
			pslverr_r <= apbAcc && (!busOpen || !mapped);
			prdata_r <= (apbAcc && !pwrite && busOpen) ? rdMux : 32'h0000_0000;
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// Control bits; defaults reload on every hub entry
	wire logic earlyDone_nxt = earlyFinish ||
		(earlyDone_r && !(wrStat && pwdata[STAT_EARLY_DONE]) && stage_r != STG_OFF);
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfgHold_r <= 1'b0;
			heldSeen_r <= 1'b0;
			chgDetEn_r <= 1'b0;
			connWait_r <= RST_CONN_WAIT;
			hsPulse_r <= 1'b0;
			earlyRun_r <= 1'b0;
			earlyDone_r <= 1'b0;
			earlyRes_r <= 1'b0;
		end
		else if (stage_r == STG_OFF)
		begin
			cfgHold_r <= dfltCfgHold;
			heldSeen_r <= 1'b0;
			chgDetEn_r <= dfltChgDet;
			connWait_r <= RST_CONN_WAIT;
			hsPulse_r <= 1'b0;
			earlyRun_r <= 1'b0;
			earlyDone_r <= 1'b0;
			earlyRes_r <= 1'b0;
		end
		else
		begin
			if (wrGate)
				cfgHold_r <= pwdata[GATE_CFG_HOLD];
			// Once held, the timeout is gone for good
			if (stage_r == STG_CONFIG && cfgHold_r)
				heldSeen_r <= 1'b1;
			if (wrCfg)
			begin
				chgDetEn_r <= pwdata[PCFG_CHG_DET_EN];
				connWait_r <= pwdata[PCFG_CONN_WAIT];
			end
			hsPulse_r <= wrGate && pwdata[GATE_HANDSHAKE] && stage_r == STG_CONNECT;
			earlyRun_r <= earlyRun_nxt;
			earlyDone_r <= earlyDone_nxt;
			if (earlyFinish)
				earlyRes_r <= chgResult;
		end
	end

	// Pin drivers
	logic upstreamDplus_r;
	logic eventOut_r;
	logic eventOe_b_r;
	logic ringOscEn_r;
	logic chgDetRun_r;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			upstreamDplus_r <= 1'b0;
			eventOut_r <= 1'b0;
			eventOe_b_r <= 1'b1;
			ringOscEn_r <= 1'b0;
			chgDetRun_r <= 1'b0;
		end
		else
		begin
			upstreamDplus_r <= stage_nxt == STG_ATTACH || stage_nxt == STG_COMM;
			eventOut_r <= 1'b0;
			eventOe_b_r <= !earlyDone_nxt;
			ringOscEn_r <= earlyRun_nxt;
			chgDetRun_r <= earlyRun_nxt || (stage_nxt == STG_CHGDET && chgDetEn_r);
		end
	end
	assign upstreamDplus = upstreamDplus_r;
	assign eventOut = eventOut_r;
	assign eventOe_b = eventOe_b_r;
	assign ringOscEn = ringOscEn_r;
	assign chgDetRun = chgDetRun_r;

	a_waitref_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_WAITREF && !refReady) |=> stage_r != STG_CONFIG)
		else $error("left wait-refclk without refclk and lock");
	a_bus_silent: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(apbAcc && stage_r == STG_WAITREF) |=> (pready_r && pslverr_r && prdata_r == 32'h0))
		else $error("serial access answered in wait-refclk");
	a_cfg_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_CONFIG && cfgHold_r && hubMode) |=> stage_r == STG_CONFIG)
		else $error("configuration left while held");
	a_cfg_early: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_CONFIG && !heldSeen_r && stgMs_r != CFG_LIM) |=> stage_r != STG_CHGDET)
		else $error("configuration left before timeout");
	a_cfg_timeout: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_CONFIG && !cfgHold_r && stgMs_r == CFG_LIM && hubMode)
		|=> stage_r == STG_CHGDET)
		else $error("configuration timeout missed");
	a_chgdet_skip: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_CHGDET && !chgDetEn_r && hubMode) |=> stage_r == STG_CONNECT)
		else $error("disabled detection not skipped");
	a_conn_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_CONNECT && connWait_r && !hsPulse_r && hubMode) |=> stage_r == STG_CONNECT)
		else $error("connect left without handshake");
	a_dplus_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(hsPulse_r && stage_r == STG_CONNECT && hubMode) |=> upstreamDplus_r
		##[40:41] (stage_r == STG_COMM || !hubMode))
		else $error("pull-up or communication late");
	a_comm_stays: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(stage_r == STG_COMM && hubMode) |=> stage_r == STG_COMM)
		else $error("communication left in hub mode");
	a_early_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
		earlyAbort |=> (!earlyRun_r && $stable(earlyDone_r) && $stable(earlyRes_r)))
		else $error("aborted detection captured a result");
	a_hub_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!hubMode |=> (stage_r == STG_OFF && !upstreamDplus_r))
		else $error("hub stage kept outside hub mode");
endmodule : hssq_sequencer

// ===== shared/hssq_pkg.sv
package hssq_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_NS = 1000000;
	localparam int US_NS = 1000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int HUBINIT_MS = 3;
	localparam int HUBCONFIG_MS = 400;
	localparam int CONTACT_DETECT_TIMEOUT_MS = 10;
	localparam int SOURCE_ENABLE_TIME_MS = 40;
	localparam int DETECT_END_DELAY_MS = 40;
	localparam int CHGDET_MS = CONTACT_DETECT_TIMEOUT_MS + 2 * SOURCE_ENABLE_TIME_MS
		+ DETECT_END_DELAY_MS;
	localparam int HUBCONNECT_TYP_US = 1;
	localparam int CONNECT_CYC = (HUBCONNECT_TYP_US * US_NS) / CLK_PERIOD_NS;
	localparam int REF_WIN_CYC = 16;
	localparam logic [7:0] ADDR_STAGE_GATE = 8'h00;
	localparam logic [7:0] ADDR_PORTABLE_CFG = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam int GATE_CFG_HOLD = 0;
	localparam int GATE_HANDSHAKE = 1;
	localparam int PCFG_CHG_DET_EN = 0;
	localparam int PCFG_CONN_WAIT = 1;
	localparam int STAT_EARLY_DONE = 8;
	localparam int STAT_EARLY_RES = 9;
	localparam logic RST_CONN_WAIT = 1'b1;
	typedef enum logic [2:0] {
		STG_OFF, STG_INIT, STG_WAITREF, STG_CONFIG,
		STG_CHGDET, STG_CONNECT, STG_ATTACH, STG_COMM
	} hssq_stage_t;
endpackage : hssq_pkg

// ===== bench/hssq_soc_model.sv
module hssq_soc_model (
	input wire logic clk_sys, // System clock
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	output logic psel, // Select
	output logic penable, // Enable
	output logic pwrite, // Direction
	output logic [7:0] paddr, // Byte address
	output logic [31:0] pwdata // Write data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// Register traffic of the host side; released data is inverted so stale words fail
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output bit ok);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		ok = 1'b0;
		n = 0;
		while (!ok && n < 16)
		begin
			@(posedge clk_sys);
			ok = (pready === 1'b1);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : hssq_soc_model

// ===== bench/tb.sv
module tb import hssq_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int M = 50;
	localparam int IMS = 2;
	localparam int CMS = 5;
	localparam int DMS = 3;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic hubRstPin_b = 1'b0;
	logic bypassPin_b = 1'b1;
	logic refClkPin = 1'b0;
	logic pllLockPin = 1'b0;
	logic dfltChgDetPin = 1'b0;
	logic dfltCfgHoldPin = 1'b0;
	logic chgResultPin = 1'b0;
	logic refOn = 1'b0;
	logic sawWaitref = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic upstreamDplus, eventOut, eventOe_b, ringOscEn, chgDetRun;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	hssq_stage_t stage;
	bit ok;
	int cyc = 0;
	int nMismatch = 0;
	int checksDone = 0;
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	always @(posedge clk_sys) if (refOn) refClkPin <= ~refClkPin;
	always @(negedge clk_sys) if (stage === STG_WAITREF) sawWaitref = 1'b1;
	hssq_sequencer #(.CYC_PER_MS_P(M), .INIT_MS(IMS), .CFG_MS(CMS), .DET_MS(DMS))
		hssq_sequencer_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hubRstPin_b(hubRstPin_b), .bypassPin_b(bypassPin_b),
		.refClkPin(refClkPin), .pllLockPin(pllLockPin), .dfltChgDetPin(dfltChgDetPin),
		.dfltCfgHoldPin(dfltCfgHoldPin), .chgResultPin(chgResultPin),
		.upstreamDplus(upstreamDplus), .eventOut(eventOut), .eventOe_b(eventOe_b),
		.ringOscEn(ringOscEn), .chgDetRun(chgDetRun), .stage(stage));
	hssq_soc_model hssq_soc_model_i (.clk_sys(clk_sys), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	task automatic endSim();
		if (nMismatch == 0 && checksDone > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : endSim
	task automatic miss(input string what);
		nMismatch++;
		$display("unexpected at %0t: %s", $time, what);
	endtask : miss
	task automatic chkBit(input logic got, input logic exp, input string what);
		checksDone++;
		if (got !== exp)
			miss(what);
	endtask : chkBit
	task automatic chkStage(input hssq_stage_t got, input hssq_stage_t exp, input string what);
		checksDone++;
		if (got !== exp)
			miss(what);
	endtask : chkStage
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hssq_soc_model_i.xfer(wr, a, d, rd, err, ok);
		if (!ok)
		begin
			miss("bus hang");
			endSim();
		end
	endtask : bus
	task automatic waitStage(input hssq_stage_t s, input int lim, output int n);
		n = 0;
		while (stage !== s)
		begin
			@(negedge clk_sys);
			n++;
			if (n > lim)
			begin
				miss("stage wait expired");
				endSim();
			end
		end
	endtask : waitStage
	task automatic enterHub(input logic det, input logic hold, input logic rf, input logic lk);
		@(posedge clk_sys);
		hubRstPin_b <= 1'b0;
		dfltChgDetPin <= det;
		dfltCfgHoldPin <= hold;
		refOn <= rf;
		pllLockPin <= lk;
		repeat (4) @(posedge clk_sys);
		chkStage(stage, STG_OFF, "hub entered early");
		hubRstPin_b <= 1'b1;
		bypassPin_b <= 1'b1;
		sawWaitref = 1'b0;
	endtask : enterHub
	task automatic leaveHub(input logic viaBypass);
		int n;
		@(posedge clk_sys);
		bypassPin_b <= !viaBypass;
		hubRstPin_b <= viaBypass;
		waitStage(STG_OFF, 6, n);
		chkBit(upstreamDplus, 1'b0, "pull-up left on");
	endtask : leaveHub
	task automatic scDirect();
		int n;
		int t0;
		enterHub(1'b1, 1'b0, 1'b1, 1'b1);
		waitStage(STG_INIT, 10, n);
		t0 = cyc;
		bus(1'b1, ADDR_STAGE_GATE, 32'h00000001);
		chkBit(err, 1'b1, "init access taken");
		waitStage(STG_CONFIG, IMS * M + M, n);
		chkBit(sawWaitref, 1'b0, "refclk wait visited");
		bus(1'b0, ADDR_PORTABLE_CFG, 32'h0);
		chkBit(rd[0] & rd[1] & !err, 1'b1, "defaults lost");
		bus(1'b0, 8'h40, 32'h0);
		chkBit(err, 1'b1, "unmapped taken");
		waitStage(STG_CHGDET, (CMS + 1) * M, n);
		n = cyc - t0;
		chkBit(n >= (IMS + CMS - 1) * M && n <= (IMS + CMS + 1) * M, 1'b1, "start delay");
		@(negedge clk_sys);
		chkBit(chgDetRun, 1'b1, "detector idle");
		waitStage(STG_CONNECT, (DMS + 1) * M, n);
		chkBit(n >= (DMS - 1) * M, 1'b1, "detection short");
		repeat (2 * M) @(negedge clk_sys);
		chkStage(stage, STG_CONNECT, "connect not held");
		chkBit(upstreamDplus, 1'b0, "pull-up early");
		bus(1'b1, ADDR_STAGE_GATE, 32'h00000002);
		waitStage(STG_COMM, 400, n);
		chkBit(upstreamDplus, 1'b1, "pull-up off");
		// The host keeps off the serial port for the whole communication stage
		repeat (3 * M) @(negedge clk_sys);
		chkStage(stage, STG_COMM, "comm left");
		leaveHub(1'b1);
	endtask : scDirect
	task automatic scEarly();
		int n;
		enterHub(1'b1, 1'b1, 1'b0, 1'b0);
		// A charger is present, so a captured result after the abort would show as bit 9
		chgResultPin <= 1'b1;
		waitStage(STG_WAITREF, IMS * M + M, n);
		repeat (2) @(negedge clk_sys);
		chkBit(ringOscEn & chgDetRun, 1'b1, "no early run");
		bus(1'b1, ADDR_STAGE_GATE, 32'h0);
		chkBit(err, 1'b1, "waitref access taken");
		pllLockPin <= 1'b1;
		repeat (6) @(negedge clk_sys);
		chkBit(ringOscEn | chgDetRun, 1'b0, "no abort");
		repeat ((DMS + 1) * M) @(negedge clk_sys);
		chkBit(eventOe_b, 1'b1, "aborted run reported");
		chkStage(stage, STG_WAITREF, "left without refclk");
		@(posedge clk_sys);
		refOn <= 1'b1;
		waitStage(STG_CONFIG, REF_WIN_CYC + 8, n);
		bus(1'b0, ADDR_STATUS, 32'h00000000);
		chkBit(rd[STAT_EARLY_DONE] | rd[STAT_EARLY_RES] | err, 1'b0, "aborted result kept");
		repeat ((CMS + 2) * M) @(negedge clk_sys);
		chkStage(stage, STG_CONFIG, "held config timed out");
		bus(1'b1, ADDR_PORTABLE_CFG, 32'h0);
		bus(1'b1, ADDR_STAGE_GATE, 32'h0);
		waitStage(STG_COMM, 80, n);
		leaveHub(1'b0);
	endtask : scEarly
	task automatic scReport();
		int n;
		enterHub(1'b1, 1'b0, 1'b0, 1'b0);
		chgResultPin <= 1'b1;
		waitStage(STG_WAITREF, IMS * M + M, n);
		n = 0;
		while (eventOe_b !== 1'b0 && n < (DMS + 2) * M)
		begin
			@(negedge clk_sys);
			n++;
		end
		chkBit(eventOe_b | eventOut, 1'b0, "early result not shown");
		@(posedge clk_sys);
		refOn <= 1'b1;
		pllLockPin <= 1'b1;
		waitStage(STG_CONFIG, REF_WIN_CYC + 8, n);
		bus(1'b0, ADDR_STATUS, 32'h00000000);
		chkBit(rd[STAT_EARLY_DONE] & rd[STAT_EARLY_RES] & !err, 1'b1, "early result lost");
		// Writing one to the done bit releases the event pin
		bus(1'b1, ADDR_STATUS, 32'h00000100);
		@(negedge clk_sys);
		chkBit(eventOe_b, 1'b1, "event pin not released");
		bus(1'b1, ADDR_STAGE_GATE, 32'h00000001);
		repeat ((CMS + 2) * M) @(negedge clk_sys);
		chkStage(stage, STG_CONFIG, "written hold ignored");
		bus(1'b1, ADDR_STAGE_GATE, 32'h0);
		waitStage(STG_CHGDET, 10, n);
		leaveHub(1'b1);
	endtask : scReport
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		scDirect();
		scEarly();
		scReport();
		endSim();
	end
endmodule : tb
